//--- shared/sbc_cfg.svh
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
// Frame layout, sent and received least significant bit first
`define FRAME_BITS 16
`define F_MODE_HI 2
`define F_MODE_LO 0
`define F_SEL_HI 5
`define F_SEL_LO 3
`define F_DATA_HI 15
`define F_DATA_LO 6
`define MODE_READ_ONLY 3'h7
// Register select codes
`define SEL_SUPERVISOR 3'h4
`define SEL_COMM 3'h5
`define SEL_WATCHDOG 3'h6
`define SEL_DIAG 3'h7
// Supervisor configuration fields
`define F_THR_HI 7
`define F_THR_LO 6
`define F_RST_DELAY 8
`define F_VCC3 9
`define F_WAKE_PIN 10
`define F_VCC2 11
`define F_FALLBACK 12
`define F_PERIODIC 13
`define F_FAILCNT 14
// Communication, watchdog and diagnosis fields
`define F_CAN_HI 7
`define F_CAN_LO 6
`define F_PERIOD_HI 10
`define F_PERIOD_LO 6
`define F_SUP_TYPE 11
`define F_RESERVED 12
`define F_SUP_EN 13
`define F_PARITY 14
`define F_PAR_HI 13
`define F_PAR_LO 6
`define F_CAUSE_HI 7
`define F_CAUSE_LO 6
// Reset values
`define RST_THRESHOLD 2'h1
`define THR_INVALID 2'h0
`define RST_DELAY 1'h1
`define RST_VCC3 1'h0
`define RST_WAKE_PIN 1'h1
`define RST_VCC2 1'h0
`define RST_FALLBACK 1'h0
`define RST_PERIODIC 1'h0
`define RST_FAILCNT 1'h1
`define RST_CAN 2'h0
`define RST_SUP_TYPE 1'h1
`define RST_SUP_EN 1'h1
`define RST_PERIOD 5'hF
`define RST_ANSWER_SEL 3'h4
// Restart cause codes
`define CAUSE_NONE 2'h0
`define CAUSE_UNDERVOLT 2'h1
`define CAUSE_WATCHDOG 2'h2
`define CAUSE_FLASH_EXT 2'h3
// Timing
`define WD_LOW_STEP_MS 16
`define WD_HIGH_STEP_MS 48
`define WD_HIGH_OFFSET_MS 464
`define WD_CODE_SPLIT 16
`define CLK_PERIOD_NS 4
`define NS_PER_MS 1000000
`define CYCLES_PER_MS_DFLT (`NS_PER_MS / `CLK_PERIOD_NS)
`endif

//--- shared/sbc_pkg.sv
package sbc_pkg;
   // Transceiver operating modes
   typedef enum logic [1:0] {
      CAN_OFF = 2'h0,
      CAN_WAKE_ONLY = 2'h1,
      CAN_RX_ONLY = 2'h2,
      CAN_NORMAL = 2'h3
   } can_mode_t;
   // Supervisor timer states, one-hot
   typedef enum logic [2:0] {
      WD_IDLE = 3'h1,
      WD_CLOSED = 3'h2,
      WD_OPEN = 3'h4
   } wd_state_t;
endpackage : sbc_pkg

//--- rtl/sbc_spi_config_diag_registers.sv
`timescale 1ns/1ns
`include "sbc_cfg.svh"
// Contract
// - Select 100 is writable, readable configuration
// - Threshold default 01; code 00 keeps previous
// - Aux regulator enables default off, write sets
// - Wake pin wakes only while enabled
// - Fallback bit set on entry condition
// - Periodic wake enable defaults off
// - One or two failures reach fallback
// - CAN mode field defaults off, four modes
// - Supervision type defaults to time-out
// - Supervisor enable defaults on, gates supervision
// - Bad parity rejects watchdog write entirely
// - Codes 16-31: code*48-464 ms
// - Codes 0-15: (code+1)*16 ms
// - Period code defaults to 01111
// - Diagnosis bits are output only
// - Restart cause encodes three reasons and none
// - Read-only read of diagnosis clears cause
// - Resume from sleep clears cause
// - Read-only answers same frame, others next
module sbc_spi_config_diag_registers #(
   parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS_DFLT
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic wake_pin,
   input wire logic undervolt_restart,
   input wire logic ext_restart,
   input wire logic resume_event,
   output logic [1:0] reset_threshold_sel,
   output logic reset_delay_long,
   output logic vcc2_enable,
   output logic vcc3_enable,
   output logic wake_pin_enable,
   output logic fallback_output_state,
   output logic periodic_wake_enable,
   output logic fail_count_to_fallback,
   output sbc_pkg::can_mode_t can_mode,
   output logic supervision_type,
   output logic supervisor_enable,
   output logic [10:0] wd_period_ms,
   output logic wd_failure,
   output logic wake_event,
   output logic [1:0] restart_cause
);

   // Period in ms for a five-bit code
   function automatic logic [10:0] period_of(input logic [4:0] code);
      logic [10:0] c;
      c = {6'h00, code};
      if (code < 5'(`WD_CODE_SPLIT)) begin
         period_of = 11'((c + 11'h001) * 11'(`WD_LOW_STEP_MS));
      end else begin
         period_of = 11'(c * 11'(`WD_HIGH_STEP_MS) - 11'(`WD_HIGH_OFFSET_MS));
      end
   endfunction : period_of
   // Parity over the watchdog frame span
   function automatic logic parity_of(input logic [15:0] w);
      parity_of = ^w[`F_PAR_HI:`F_PAR_LO];
   endfunction : parity_of
   // Link side, clocked by spi_sck
   logic [3:0] bit_cnt_q; // Bits taken this frame
   logic [15:0] shift_q; // Frame being assembled
   logic [15:0] rx_word_q; // Last complete frame
   logic full_q; // A complete frame is held
   logic miso_q; // Serial answer bit
   logic [9:0] snap_q [4]; // Register images, set by system side
   logic [2:0] answer_sel_q; // Select answered in the coming frame
   logic [2:0] tx_sel; // Register chosen for this frame's data
   logic [15:0] tx_word; // Frame being sent
   // Assembly; the chip select ends the frame, since the link clock stops
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         bit_cnt_q <= 4'h0;
         shift_q <= 16'h0000;
      end else begin
         shift_q[bit_cnt_q] <= spi_mosi;
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end
   // Complete frame capture; stays stable while the select is high
   always_ff @(posedge spi_sck) begin
      if (bit_cnt_q == 4'hF) begin
         rx_word_q <= {spi_mosi, shift_q[14:0]};
         full_q <= 1'b1;
      end else if (bit_cnt_q == 4'h0) begin
         full_q <= 1'b0;
      end
   end
   // Data selection: a read-only frame answers its own select
   always_comb begin
      if (shift_q[`F_MODE_HI:`F_MODE_LO] == `MODE_READ_ONLY && bit_cnt_q > 4'(`F_SEL_HI)) begin
         tx_sel = shift_q[`F_SEL_HI:`F_SEL_LO];
      end else begin
         tx_sel = answer_sel_q;
      end
      tx_word = {(tx_sel[2] ? snap_q[tx_sel[1:0]] : 10'h000), answer_sel_q, 3'h0};
   end
   // Answer shifts out on the falling edge; bit zero is always low
   always_ff @(negedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= tx_word[bit_cnt_q];
      end
   end
   assign spi_miso = miso_q;

   // System side, clocked by clk_sys
   logic [2:0] cs_sync_q; // Select synchroniser plus edge stage
   logic [3:0] in_s1_q; // First stage of pin synchronisers
   logic [3:0] in_s2_q; // Second stage
   logic [3:0] in_s3_q; // Edge detection stage
   logic frame_acc; // One frame taken
   logic [15:0] fw; // Frame word under decode
   logic [2:0] f_sel;
   logic f_ro;
   logic f_wr;
   logic wd_touch; // Frame that retriggers the supervisor
   logic wr_ok_wd; // Watchdog write with good parity
   logic [31:0] ms_div_q; // Millisecond prescaler
   logic ms_tick;
   logic [10:0] ms_cnt_q; // Elapsed ms in current period
   sbc_pkg::wd_state_t wd_state_q;
   logic [4:0] period_code_q; // Watchdog period code
   logic first_fail_q; // One failure seen, waiting for a second
   logic fail_ev; // Supervision failure this cycle
   logic fb_set; // Fallback entry this cycle
   logic cause_clr;
   logic [1:0] cause_set;
   // Select and pin synchronisers; only stage two and later are read
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cs_sync_q <= 3'h7;
         in_s1_q <= 4'h0;
         in_s2_q <= 4'h0;
         in_s3_q <= 4'h0;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], spi_cs_n};
         in_s1_q <= {resume_event, ext_restart, undervolt_restart, wake_pin};
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
      end
   end
   // Frame decode; the held word is quiet once the select has risen
   always_comb begin
      frame_acc = cs_sync_q[1] && !cs_sync_q[2] && full_q;
      fw = rx_word_q;
      f_sel = fw[`F_SEL_HI:`F_SEL_LO];
      f_ro = fw[`F_MODE_HI:`F_MODE_LO] == `MODE_READ_ONLY;
      f_wr = frame_acc && !f_ro;
      wr_ok_wd = f_wr && f_sel == `SEL_WATCHDOG && parity_of(fw) == fw[`F_PARITY];
      wd_touch = frame_acc && (f_ro || f_sel == `SEL_WATCHDOG) && !(f_wr && !wr_ok_wd);
   end
   // Supervisor configuration register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         reset_threshold_sel <= `RST_THRESHOLD;
         reset_delay_long <= `RST_DELAY;
         vcc3_enable <= `RST_VCC3;
         vcc2_enable <= `RST_VCC2;
         wake_pin_enable <= `RST_WAKE_PIN;
         periodic_wake_enable <= `RST_PERIODIC;
         fail_count_to_fallback <= `RST_FAILCNT;
      end else if (f_wr && f_sel == `SEL_SUPERVISOR) begin
         // An invalid threshold code leaves the old level in force
         if (fw[`F_THR_HI:`F_THR_LO] != `THR_INVALID) begin
            reset_threshold_sel <= fw[`F_THR_HI:`F_THR_LO];
         end
         reset_delay_long <= fw[`F_RST_DELAY];
         vcc3_enable <= fw[`F_VCC3];
         vcc2_enable <= fw[`F_VCC2];
         wake_pin_enable <= fw[`F_WAKE_PIN];
         periodic_wake_enable <= fw[`F_PERIODIC];
         fail_count_to_fallback <= fw[`F_FAILCNT];
      end
   end
   // Fallback output; an entry condition wins over a write in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fallback_output_state <= `RST_FALLBACK;
      end else if (fb_set) begin
         fallback_output_state <= 1'b1;
      end else if (f_wr && f_sel == `SEL_SUPERVISOR) begin
         fallback_output_state <= fw[`F_FALLBACK];
      end
   end
   // Communication setup register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         can_mode <= sbc_pkg::can_mode_t'(`RST_CAN);
      end else if (f_wr && f_sel == `SEL_COMM) begin
         can_mode <= sbc_pkg::can_mode_t'(fw[`F_CAN_HI:`F_CAN_LO]);
      end
   end
   // Watchdog register; reserved bit is not stored, it always reads one
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         supervision_type <= `RST_SUP_TYPE;
         supervisor_enable <= `RST_SUP_EN;
         period_code_q <= `RST_PERIOD;
      end else if (wr_ok_wd) begin
         supervision_type <= fw[`F_SUP_TYPE];
         supervisor_enable <= fw[`F_SUP_EN];
         period_code_q <= fw[`F_PERIOD_HI:`F_PERIOD_LO];
      end
   end
   // Period decode kept registered so the output is a flop
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wd_period_ms <= period_of(`RST_PERIOD);
      end else begin
         wd_period_ms <= period_of(period_code_q);
      end
   end
   // Millisecond prescaler
   always_ff @(posedge clk_sys) begin
      if (!reset_n || ms_tick) begin
         ms_div_q <= 32'h0000_0000;
      end else begin
         ms_div_q <= ms_div_q + 32'h0000_0001;
      end
   end
   assign ms_tick = ms_div_q == CYCLES_PER_MS - 1;
   // Supervision timer; window mode closes the first half of the period
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wd_state_q <= sbc_pkg::WD_IDLE;
         ms_cnt_q <= 11'h000;
         wd_failure <= 1'b0;
      end else begin
         wd_failure <= 1'b0;
         unique case (wd_state_q)
            sbc_pkg::WD_IDLE: begin
               ms_cnt_q <= 11'h000;
               if (supervisor_enable) begin
                  wd_state_q <= supervision_type ? sbc_pkg::WD_OPEN : sbc_pkg::WD_CLOSED;
               end
            end
            sbc_pkg::WD_CLOSED: begin
               if (wd_touch) begin
                  wd_failure <= 1'b1;
                  ms_cnt_q <= 11'h000;
               end else if (ms_cnt_q >= (wd_period_ms >> 1)) begin
                  wd_state_q <= sbc_pkg::WD_OPEN;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 11'h001;
               end
            end
            sbc_pkg::WD_OPEN: begin
               if (wd_touch || ms_cnt_q >= wd_period_ms) begin
                  wd_failure <= !wd_touch;
                  ms_cnt_q <= 11'h000;
                  wd_state_q <= supervision_type ? sbc_pkg::WD_OPEN : sbc_pkg::WD_CLOSED;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 11'h001;
               end
            end
         endcase
         // Disabling supervision drops the timer at once
         if (!supervisor_enable) begin
            wd_state_q <= sbc_pkg::WD_IDLE;
         end
      end
   end
   assign fail_ev = wd_failure;
   // Consecutive failure tracking; a good trigger forgets the first one
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         first_fail_q <= 1'b0;
      end else if (fail_ev && fail_count_to_fallback) begin
         first_fail_q <= !first_fail_q;
      end else if (wd_touch && wd_state_q == sbc_pkg::WD_OPEN) begin
         first_fail_q <= 1'b0;
      end
   end
   assign fb_set = fail_ev && (!fail_count_to_fallback || first_fail_q);
   // Restart cause; any new cause wins over a clear in the same cycle
   always_comb begin
      cause_clr = (frame_acc && f_ro && f_sel == `SEL_DIAG)
         || (in_s2_q[3] && !in_s3_q[3]);
      if (in_s2_q[2] && !in_s3_q[2]) begin
         cause_set = `CAUSE_FLASH_EXT;
      end else if (fail_ev && fail_count_to_fallback && !first_fail_q) begin
         cause_set = `CAUSE_WATCHDOG;
      end else if (in_s2_q[1] && !in_s3_q[1]) begin
         cause_set = `CAUSE_UNDERVOLT;
      end else begin
         cause_set = `CAUSE_NONE;
      end
   end
   // Cause register; writes to the diagnosis select are ignored
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         restart_cause <= `CAUSE_NONE;
      end else if (cause_set != `CAUSE_NONE) begin
         restart_cause <= cause_set;
      end else if (cause_clr) begin
         restart_cause <= `CAUSE_NONE;
      end
   end
   // Wake requests from the pin, either edge, only while enabled
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wake_event <= 1'b0;
      end else begin
         wake_event <= wake_pin_enable && (in_s2_q[0] != in_s3_q[0]);
      end
   end
   // Answer select and register images; frozen while a frame runs
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         answer_sel_q <= `RST_ANSWER_SEL;
         for (int i = 0; i < 4; i++) begin
            snap_q[i] <= 10'h000;
         end
      end else if (cs_sync_q[1]) begin
         if (frame_acc) begin
            answer_sel_q <= f_sel;
         end
         snap_q[0] <= {1'b0, fail_count_to_fallback, periodic_wake_enable, fallback_output_state,
            vcc2_enable, wake_pin_enable, vcc3_enable, reset_delay_long, reset_threshold_sel};
         snap_q[1] <= {8'h00, can_mode};
         snap_q[2] <= {1'b0, parity_of({2'h0, supervisor_enable, 1'b1, supervision_type, period_code_q, 6'h00}),
            supervisor_enable, 1'b1, supervision_type, period_code_q};
         snap_q[3] <= {8'h00, restart_cause};
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_thr_invalid: assert property (f_wr && f_sel == `SEL_SUPERVISOR && fw[7:6] == 2'h0
      |=> reset_threshold_sel == $past(reset_threshold_sel)) else $error("threshold changed on code 00");
   a_thr_written: assert property (f_wr && f_sel == `SEL_SUPERVISOR && fw[7:6] != 2'h0
      |=> reset_threshold_sel == $past(fw[7:6])) else $error("threshold write lost");
   a_parity_reject: assert property (f_wr && f_sel == `SEL_WATCHDOG && parity_of(fw) != fw[14]
      |=> $stable(period_code_q) && $stable(supervisor_enable)) else $error("bad parity accepted");
   a_period_map: assert property (##1 wd_period_ms == (($past(period_code_q) < 5'h10)
      ? 11'(({6'h00, $past(period_code_q)} + 11'h001) << 4)
      : 11'({6'h00, $past(period_code_q)} * 11'h030 - 11'h1D0))) else $error("period decode wrong");
   a_early_fail: assert property (wd_state_q == sbc_pkg::WD_CLOSED && wd_touch
      |=> wd_failure) else $error("early trigger not failed");
   a_single_fail: assert property (wd_failure && !fail_count_to_fallback
      |=> fallback_output_state) else $error("single failure did not reach fallback");
   a_wake_gate: assert property (wake_event |-> $past(wake_pin_enable))
      else $error("wake while disabled");
   a_cause_ro_clear: assert property (frame_acc && f_ro && f_sel == `SEL_DIAG && cause_set == 2'h0
      |=> restart_cause == 2'h0) else $error("cause not cleared on read");
   a_can_write: assert property (f_wr && f_sel == `SEL_COMM |=> can_mode == $past(fw[7:6]))
      else $error("can mode write lost");
   a_reset_vals: assert property (@(posedge clk_sys) disable iff (1'b0) !reset_n
      |=> period_code_q == 5'hF && wake_pin_enable && can_mode == sbc_pkg::CAN_OFF) else $error("bad reset value");
   c_ro_read: cover property (frame_acc && f_ro);
   c_wd_write: cover property (wr_ok_wd);
   c_fallback: cover property ($rose(fallback_output_state));
   c_cause_wd: cover property (restart_cause == 2'h2);
endmodule : sbc_spi_config_diag_registers

//--- bench/spi_master_model.sv
`timescale 1ns/1ns
`include "sbc_cfg.svh"
// Controller side of the serial link: frames LSB first, 48 ns link period
module spi_master_model (
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   localparam int HALF_NS = 24; // Half link period
   logic [15:0] rx_q; // Answer gathered in the last frame
   // Link idles with select high and clock still
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      rx_q = 16'h0000;
   end
   // One whole frame of exactly 16 rising edges
   task automatic xfer(input logic [15:0] tx);
      #7;
      spi_cs_n = 1'b0;
      #HALF_NS;
      for (int k = 0; k < 16; k++) begin
         spi_mosi = tx[k];
         #HALF_NS;
         spi_sck = 1'b1;
         rx_q[k] = spi_miso;
         #HALF_NS;
         spi_sck = 1'b0;
      end
      // Invert the data line so nothing can live off a stale level
      spi_mosi = ~spi_mosi;
      #HALF_NS;
      spi_cs_n = 1'b1;
      #64; // Gap well above 4 system cycles
   endtask : xfer
   // Write frame; watchdog frames carry fixed bit and parity, wrong only when asked
   task automatic write(input logic [2:0] sel, input logic [9:0] data, input logic bad_par);
      logic [15:0] f;
      f = {data, sel, 3'h0};
      if (sel == `SEL_WATCHDOG) begin
         f[12] = 1'b1;
         f[14] = (^f[13:6]) ^ bad_par;
      end
      xfer(f);
   endtask : write
   // Read-only frame, answered within the same frame
   task automatic read_only(input logic [2:0] sel);
      xfer({10'h000, sel, `MODE_READ_ONLY});
   endtask : read_only
endmodule : spi_master_model

//--- bench/sbc_spi_config_diag_registers_test.sv
`timescale 1ns/1ns
`include "sbc_cfg.svh"
`define CHECK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module sbc_spi_config_diag_registers_test;
   localparam int unsigned CPM = 40; // Short millisecond keeps watchdog periods in reach
   logic clk_sys, reset_n, spi_sck, spi_cs_n, spi_mosi, spi_miso;
   logic wake_pin, undervolt_restart, ext_restart, resume_event;
   logic [1:0] reset_threshold_sel, restart_cause;
   logic reset_delay_long, vcc2_enable, vcc3_enable, wake_pin_enable, fallback_output_state;
   logic periodic_wake_enable, fail_count_to_fallback, supervision_type, supervisor_enable;
   logic wd_failure, wake_event;
   logic [10:0] wd_period_ms;
   sbc_pkg::can_mode_t can_mode;
   int num_errors = 0;
   int n_checks = 0;
   int fail_cnt = 0; // Supervision failure pulses seen
   int wake_cnt = 0; // Wake pulses seen
   sbc_spi_config_diag_registers #(.CYCLES_PER_MS(CPM)) u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .wake_pin(wake_pin),
      .undervolt_restart(undervolt_restart), .ext_restart(ext_restart), .resume_event(resume_event),
      .reset_threshold_sel(reset_threshold_sel), .reset_delay_long(reset_delay_long),
      .vcc2_enable(vcc2_enable), .vcc3_enable(vcc3_enable), .wake_pin_enable(wake_pin_enable),
      .fallback_output_state(fallback_output_state), .periodic_wake_enable(periodic_wake_enable),
      .fail_count_to_fallback(fail_count_to_fallback), .can_mode(can_mode),
      .supervision_type(supervision_type), .supervisor_enable(supervisor_enable),
      .wd_period_ms(wd_period_ms), .wd_failure(wd_failure), .wake_event(wake_event),
      .restart_cause(restart_cause)
   );
   spi_master_model u_master (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Pulses are one cycle wide, so count them on every rising edge
   always @(posedge clk_sys) begin
      if (wd_failure === 1'b1) fail_cnt++;
      if (wake_event === 1'b1) wake_cnt++;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic end_of_test;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   // Bounded wait for the failure count to reach a target
   task automatic wait_fails(input int target);
      int n;
      n = 0;
      while (fail_cnt < target && n < 3000) begin
         cyc(1);
         n++;
      end
      if (fail_cnt < target) begin
         num_errors++;
         $display("ERROR %0t: no supervision failure", $time);
         end_of_test();
      end
   endtask : wait_fails
   task automatic t_defaults;
      `CHECK(reset_threshold_sel, 2'h1)
      `CHECK({vcc2_enable, vcc3_enable}, 2'h0)
      `CHECK(wake_pin_enable, 1'b1)
      `CHECK(fallback_output_state, 1'b0)
      `CHECK(periodic_wake_enable, 1'b0)
      `CHECK(fail_count_to_fallback, 1'b1)
      `CHECK(can_mode, sbc_pkg::CAN_OFF)
      `CHECK(supervision_type, 1'b1)
      `CHECK(supervisor_enable, 1'b1)
      `CHECK(wd_period_ms, 11'h100)
      u_master.read_only(`SEL_SUPERVISOR);
      `CHECK(u_master.rx_q[14:6], 9'h115)
   endtask : t_defaults
   task automatic t_supervisor;
      int w0;
      u_master.write(`SEL_SUPERVISOR, 10'h0AA, 1'b0);
      `CHECK(reset_threshold_sel, 2'h2)
      `CHECK(reset_delay_long, 1'b0)
      `CHECK({vcc2_enable, vcc3_enable, periodic_wake_enable}, 3'h7)
      `CHECK(fail_count_to_fallback, 1'b0)
      w0 = wake_cnt;
      wake_pin = ~wake_pin;
      cyc(10);
      `CHECK(wake_cnt, w0)
      // Code 00 must leave the threshold alone while the rest applies
      u_master.write(`SEL_SUPERVISOR, 10'h0B8, 1'b0);
      `CHECK(reset_threshold_sel, 2'h2)
      `CHECK(wake_pin_enable, 1'b1)
      wake_pin = ~wake_pin;
      cyc(10);
      `CHECK(wake_cnt, w0 + 1)
      for (int m = 0; m < 4; m++) begin
         u_master.write(`SEL_COMM, {8'h00, m[1:0]}, 1'b0);
         `CHECK(can_mode, sbc_pkg::can_mode_t'(m[1:0]))
         `CHECK(u_master.rx_q[7:3], (m == 0) ? 5'h14 : {2'(m - 1), 3'h5})
      end
   endtask : t_supervisor
   task automatic t_watchdog;
      int codes[6] = '{0, 1, 15, 16, 17, 31};
      int exp;
      foreach (codes[i]) begin
         exp = (codes[i] < 16) ? (codes[i] + 1) * 16 : codes[i] * 48 - 464;
         u_master.write(`SEL_WATCHDOG, {5'h07, 5'(codes[i])}, 1'b0);
         `CHECK(wd_period_ms, 11'(exp))
      end
      u_master.write(`SEL_WATCHDOG, {5'h07, 5'h00}, 1'b1);
      `CHECK(wd_period_ms, 11'h400)
      u_master.read_only(`SEL_WATCHDOG);
      `CHECK(u_master.rx_q[13:6], 8'hFF)
   endtask : t_watchdog
   // Window mode, one failure goes straight to fallback
   task automatic t_window;
      int f0;
      f0 = fail_cnt;
      u_master.write(`SEL_WATCHDOG, {5'h06, 5'h00}, 1'b0);
      u_master.write(`SEL_WATCHDOG, {5'h06, 5'h00}, 1'b0);
      // Third trigger lands inside the closed half, so it is an early failure
      u_master.write(`SEL_WATCHDOG, {5'h06, 5'h00}, 1'b0);
      wait_fails(f0 + 1);
      cyc(3);
      `CHECK(fallback_output_state, 1'b1)
      u_master.write(`SEL_WATCHDOG, {5'h03, 5'h00}, 1'b0);
      `CHECK(supervisor_enable, 1'b0)
      f0 = fail_cnt;
      cyc(1000);
      `CHECK(fail_cnt, f0)
   endtask : t_window
   // Time-out mode, two consecutive failures needed
   task automatic t_timeout;
      int f0;
      u_master.write(`SEL_SUPERVISOR, 10'h1BA, 1'b0);
      `CHECK(fallback_output_state, 1'b0)
      f0 = fail_cnt;
      u_master.write(`SEL_WATCHDOG, {5'h07, 5'h00}, 1'b0);
      wait_fails(f0 + 1);
      cyc(3);
      `CHECK({restart_cause, fallback_output_state}, 3'h4)
      wait_fails(f0 + 2);
      cyc(3);
      `CHECK(fallback_output_state, 1'b1)
      u_master.write(`SEL_WATCHDOG, {5'h03, 5'h00}, 1'b0);
      u_master.read_only(`SEL_DIAG);
      `CHECK(u_master.rx_q[7:6], 2'h2)
      `CHECK(restart_cause, 2'h0)
   endtask : t_timeout
   task automatic t_cause;
      undervolt_restart = 1'b1;
      cyc(8);
      undervolt_restart = 1'b0;
      `CHECK(restart_cause, 2'h1)
      resume_event = 1'b1;
      cyc(8);
      resume_event = 1'b0;
      `CHECK(restart_cause, 2'h0)
      ext_restart = 1'b1;
      cyc(8);
      ext_restart = 1'b0;
      `CHECK(restart_cause, 2'h3)
      u_master.write(`SEL_DIAG, 10'h000, 1'b0);
      `CHECK(restart_cause, 2'h3)
      u_master.read_only(`SEL_DIAG);
      `CHECK(u_master.rx_q[7:6], 2'h3)
      `CHECK(restart_cause, 2'h0)
   endtask : t_cause
   // Main sequence: reset for 5 cycles, then each scenario in turn
   initial begin
      reset_n = 1'b0;
      wake_pin = 1'b0;
      undervolt_restart = 1'b0;
      ext_restart = 1'b0;
      resume_event = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      cyc(5);
      t_defaults();
      t_supervisor();
      t_watchdog();
      t_window();
      t_timeout();
      t_cause();
      end_of_test();
   end
endmodule : sbc_spi_config_diag_registers_test
